// [rtl/imm_exec_pkg.sv]
/*
   Constants for the and-immediate and conditional branch execute block.
   Assumes one core clock and an asynchronous active-low core reset.
*/
// Contract
// [RL1] And-immediate writes operand AND zero-extended immediate.
// [RL2] Immediate unsigned; and-immediate never raises exceptions.
// [RL3] Equal branch: PC+4+offset when equal, else PC+4.
// [RL4] Offset is signed bytes from next instruction.
// [RL5] Software keeps offset low two bits zero.
// [RL6] Misaligned taken target raises exception, no jump.
// [RL7] Equal branch decodes both indices and signed immediate.
// [RL8] Signed compare branch: taken when first >= second.
// [RL9] Fields 31:27, 26:22, 21:6, opcode 5:0.
`default_nettype none
package imm_exec_pkg;
   localparam int         FIRST_IDX_MSB  = 31;
   localparam int         FIRST_IDX_LSB  = 27;
   localparam int         SECOND_IDX_MSB = 26;
   localparam int         SECOND_IDX_LSB = 22;
   localparam int         IMM_MSB        = 21;
   localparam int         IMM_LSB        = 6;
   localparam int         OPCODE_MSB     = 5;
   localparam int         OPCODE_LSB     = 0;
   localparam logic [5:0] OP_ANDI        = 6'h0c;
   localparam logic [5:0] OP_BEQ         = 6'h26;
   localparam logic [5:0] OP_BGE         = 6'h0e;
   localparam logic [31:0] PC_STEP       = 32'h0000_0004;
   localparam logic [15:0] UPPER_ZERO    = 16'h0000;
   localparam logic [31:0] PC_RESET      = 32'h0000_0000;
endpackage
`default_nettype wire

// [rtl/imm_exec.sv]
/*
   Decode and execute of and-immediate, branch-if-equal and signed
   branch-if-greater-or-equal. Assumes fetch presents an instruction with
   a one-cycle valid pulse together with its PC and both source values
   already read from the register file; results appear one cycle later.
*/
`timescale 1ns/10ps
`default_nettype none
module imm_exec
   import imm_exec_pkg::*;
(
   // Clock and reset.
   input  wire logic        sys_clk_i,
   input  wire logic        reset_n_i,
   // Instruction from fetch.
   input  wire logic        instr_valid_i,
   input  wire logic [31:0] instr_i,
   input  wire logic [31:0] pc_i,
   // Source operands.
   input  wire logic [31:0] first_source_reg_i,
   input  wire logic [31:0] second_source_reg_i,
   // Register file read indices.
   output logic [4:0]       first_idx_o,
   output logic [4:0]       second_idx_o,
   // Register file write.
   output logic             wr_en_o,
   output logic [4:0]       wr_idx_o,
   output logic [31:0]      wr_data_o,
   // Program counter update.
   output logic             pc_load_o,
   output logic [31:0]      next_pc_o,
   // Exception.
   output logic             misaligned_exc_o,
   output logic [31:0]      exc_target_o
);

   // Decoded fields and operands of the instruction at the input.
   logic [5:0]  opcode;
   logic [15:0] immediate_field;
   logic [31:0] offset;
   logic [31:0] fall_through;
   logic [31:0] target;
   logic        is_andi;
   logic        is_branch;
   logic        taken;
   logic        andi_fire;
   logic        branch_fire;
   logic        target_fault;
   logic [31:0] next_wr_data;
   logic [31:0] next_pc;

   // Returns the operation code of an instruction word.
   function automatic logic [5:0] opcode_of(input logic [31:0] word);
      return word[OPCODE_MSB:OPCODE_LSB];
   endfunction

   // Returns the index of the first source register.
   function automatic logic [4:0] first_index_of(input logic [31:0] word);
      return word[FIRST_IDX_MSB:FIRST_IDX_LSB];
   endfunction

   // Returns the index of the second register.
   function automatic logic [4:0] second_index_of(input logic [31:0] word);
      return word[SECOND_IDX_MSB:SECOND_IDX_LSB];
   endfunction

   // Returns the 16-bit immediate field.
   function automatic logic [15:0] immediate_of(input logic [31:0] word);
      return word[IMM_MSB:IMM_LSB];
   endfunction

   // Sign extends a branch offset to the address width.
   function automatic logic [31:0] sign_extend(input logic [15:0] value);
      return {{16{value[15]}}, value};
   endfunction

   // Zero extends an and-immediate operand, so the upper halfword is clear.
   function automatic logic [31:0] zero_extend(input logic [15:0] value);
      return {UPPER_ZERO, value};
   endfunction

   // True for the and-immediate code.
   function automatic logic is_andi_op(input logic [5:0] op);
      return (op == OP_ANDI);
   endfunction

   // True for the two conditional branch codes.
   function automatic logic is_branch_op(input logic [5:0] op);
      return (op == OP_BEQ) || (op == OP_BGE);
   endfunction

   // Decides whether a conditional branch is taken.
   function automatic logic branch_taken(input logic [5:0]  op,
                                         input logic [31:0] lhs,
                                         input logic [31:0] rhs);
      logic result;
      case (op)
         OP_BEQ: begin
            result = (lhs == rhs);
         end
         OP_BGE: begin
            result = ($signed(lhs) >= $signed(rhs));
         end
         default: begin
            result = 1'b0;
         end
      endcase
      return result;
   endfunction

   // True when an address lies on a word boundary.
   function automatic logic word_aligned(input logic [31:0] addr);
      return (addr[1:0] == 2'h0);
   endfunction

   // Field decode and address arithmetic.
   assign opcode          = opcode_of(instr_i);                 // see [RL9]
   assign immediate_field = immediate_of(instr_i);              // see [RL7]
   assign offset          = sign_extend(immediate_field);       // see [RL4]
   assign fall_through    = pc_i + PC_STEP;                     // see [RL4]
   assign target          = fall_through + offset;              // see [RL4]
   assign is_andi         = is_andi_op(opcode);                 // see [RL9]
   assign is_branch       = is_branch_op(opcode);               // see [RL9]
   assign taken           = branch_taken(opcode,       // see [RL3] [RL8]
                                         first_source_reg_i,
                                         second_source_reg_i);

   // Qualified requests of this cycle.
   assign andi_fire    = instr_valid_i && is_andi;              // see [RL2]
   assign branch_fire  = instr_valid_i && is_branch;
   assign target_fault = taken && !word_aligned(target);        // see [RL6]

   // Values loaded into the result registers.
   assign next_wr_data = first_source_reg_i &
                         zero_extend(immediate_field);          // see [RL1]
   assign next_pc      = taken ? target : fall_through;     // see [RL3] [RL8]

   // Index of the first source register for the register file read.
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         first_idx_o <= 5'h00;
      end else begin
         first_idx_o <= first_index_of(instr_i);                // see [RL7]
      end
   end

   // Index of the second register for the register file read.
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         second_idx_o <= 5'h00;
      end else begin
         second_idx_o <= second_index_of(instr_i);              // see [RL7]
      end
   end

   // Write strobe of the and-immediate result.
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wr_en_o <= 1'b0;
      end else begin
         wr_en_o <= andi_fire;                                  // see [RL1]
      end
   end

   // Destination index of the and-immediate result.
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wr_idx_o <= 5'h00;
      end else begin
         if (andi_fire) begin
            wr_idx_o <= second_index_of(instr_i);               // see [RL1]
         end
      end
   end

   // Data of the and-immediate result.
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wr_data_o <= 32'h0000_0000;
      end else begin
         if (andi_fire) begin
            wr_data_o <= next_wr_data;                    // see [RL1] [RL2]
         end
      end
   end

   // Load strobe of the program counter.
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pc_load_o <= 1'b0;
      end else begin
         pc_load_o <= branch_fire && !target_fault;             // see [RL6]
      end
   end

   // New program counter of a branch that does not fault.
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         next_pc_o <= PC_RESET;
      end else begin
         if (branch_fire && !target_fault) begin
            next_pc_o <= next_pc;                         // see [RL3] [RL8]
         end
      end
   end

   // Misaligned target exception strobe.
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         misaligned_exc_o <= 1'b0;
      end else begin
         misaligned_exc_o <= branch_fire && target_fault;       // see [RL6]
      end
   end

   // Offending target of a misaligned branch.
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         exc_target_o <= PC_RESET;
      end else begin
         if (branch_fire && target_fault) begin
            exc_target_o <= target;                             // see [RL6]
         end
      end
   end

endmodule // imm_exec
`default_nettype wire

// [verif/imm_exec_sva.sv]
/* Checker for imm_exec ports. Assumes it is bound to every imm_exec. */
`timescale 1ns/10ps
`default_nettype none
module imm_exec_chk (
   input wire logic        sys_clk_i, reset_n_i, instr_valid_i, wr_en_o,
   input wire logic        pc_load_o, misaligned_exc_o,
   input wire logic [31:0] instr_i, pc_i, first_source_reg_i, wr_data_o,
   input wire logic [31:0] second_source_reg_i, next_pc_o, exc_target_o,
   input wire logic [4:0]  first_idx_o, second_idx_o, wr_idx_o);
   logic [31:0] a, tg;
   logic        an, br, tk, ok;
   assign a = first_source_reg_i;
   assign an = instr_valid_i && instr_i[5:0] == 6'h0c;
   assign br = instr_valid_i && instr_i[5:0] inside {6'h26, 6'h0e};
   assign tk = instr_i[5] ? a == second_source_reg_i
      : $signed(a) >= $signed(second_source_reg_i);
   assign tg = pc_i + 32'h4 + {{16{instr_i[21]}}, instr_i[21:6]};
   assign ok = pc_load_o && !misaligned_exc_o;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!reset_n_i);
   // Steps of a request and its one-cycle answer.
   sequence andi_req_s;
      an;
   endsequence
   sequence branch_req_s;
      br;
   endsequence
   sequence write_pulse_s;
      wr_en_o ##1 !wr_en_o;
   endsequence
   andi_write_a: assert property ($past(an) |-> wr_en_o &&
      wr_data_o == ($past(a) & {16'h0000, $past(instr_i[21:6])}))
      else $error("and-immediate result wrong");
   andi_quiet_a: assert property ($past(an) |-> !pc_load_o &&
      !misaligned_exc_o) else $error("and-immediate touched the PC");
   taken_jump_a: assert property (
      $past(br && tk && tg[1:0] == 2'h0) |-> ok && next_pc_o == $past(tg))
      else $error("taken branch target wrong");
   fall_through_a: assert property (
      $past(br && !tk) |-> ok && next_pc_o == $past(pc_i) + 32'h0000_0004)
      else $error("not-taken branch address wrong");
   bad_target_a: assert property (
      $past(br && tk && tg[1:0] != 2'h0) |-> misaligned_exc_o && !pc_load_o
      && exc_target_o == $past(tg)) else $error("misaligned target missed");
   index_copy_a: assert property ($past(instr_valid_i) |->
      {first_idx_o, second_idx_o} == $past(instr_i[31:22]))
      else $error("register indices wrong");
   dest_index_a: assert property (wr_en_o |->
      wr_idx_o == $past(instr_i[26:22])) else $error("write index wrong");
   other_op_a: assert property (
      $past(instr_valid_i && !an && !br) |->
      !wr_en_o && !pc_load_o && !misaligned_exc_o)
      else $error("unknown opcode answered");
   write_pulse_a: assert property (andi_req_s ##1 !an |->
      write_pulse_s) else $error("write pulse length wrong");
   branch_once_a: assert property (branch_req_s |=>
      pc_load_o != misaligned_exc_o) else $error("branch answer not single");
endmodule // imm_exec_chk
bind imm_exec imm_exec_chk u_chk (.*);
`default_nettype wire

// [verif/imm_exec_test.sv]
/* Bench for imm_exec. Assumes the imm_exec_pkg constants. */
`timescale 1ns/10ps
`default_nettype none
module imm_exec_test;
   import imm_exec_pkg::*;
   logic sys_clk_i = 0, reset_n_i = 0, instr_valid_i = 0, wr_en_o, pc_load_o;
   logic misaligned_exc_o;
   logic [31:0] instr_i = 0, pc_i = 0, first_source_reg_i = 0, t, next_pc_o;
   logic [31:0] second_source_reg_i = 0, wr_data_o, exc_target_o;
   logic [4:0]  first_idx_o, second_idx_o, wr_idx_o;
   logic [15:0] lf = 16'h1fba;
   logic [5:0]  ops[4] = '{OP_ANDI, OP_BEQ, OP_BGE, 6'h3a};
   logic [34:0] q[$];
   int n_mismatch = 0, samples_checked = 0;
   imm_exec u_dut (.*);
   always #5 sys_clk_i = ~sys_clk_i;
   function automatic logic [31:0] rnd();
      lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
      return {lf, lf[7:0], ~lf[15:8]};
   endfunction
   task automatic go(input logic [5:0] op, input logic eq);
      @(posedge sys_clk_i) #1;
      first_source_reg_i = rnd();
      second_source_reg_i = eq ? first_source_reg_i : rnd();
      pc_i = rnd() & 32'hffff_fffc;
      t = rnd();
      if (eq) t[7:6] = 2'h0;
      instr_i = {t[31:6], op};
      instr_valid_i = 1'h1;
      t = pc_i + PC_STEP + {{16{t[21]}}, t[21:6]};
      if (op == OP_ANDI)
         q.push_back({3'h4, first_source_reg_i &
            {UPPER_ZERO, instr_i[21:6]}});
      else if (op == OP_BEQ && first_source_reg_i == second_source_reg_i ||
         op == OP_BGE && $signed(first_source_reg_i) >=
         $signed(second_source_reg_i))
         q.push_back({t[1:0] ? 3'h1 : 3'h2, t});
      else if (op inside {OP_BEQ, OP_BGE})
         q.push_back({3'h2, pc_i + PC_STEP});
   endtask
   always @(posedge sys_clk_i) begin
      #2;
      if (wr_en_o | pc_load_o | misaligned_exc_o) begin
         samples_checked++;
         if (q.size() == 0 || q.pop_front() !== {wr_en_o, pc_load_o,
            misaligned_exc_o, wr_en_o ? wr_data_o : pc_load_o ? next_pc_o :
            exc_target_o}) begin
            n_mismatch++;
            $display("Error %0t: result differs", $time);
         end
      end
   end
   task automatic finish_test();
      if (n_mismatch == 0 && samples_checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge sys_clk_i);
      samples_checked++;
      if ({wr_en_o, pc_load_o, misaligned_exc_o, wr_data_o, next_pc_o,
         exc_target_o, first_idx_o, second_idx_o, wr_idx_o} !== '0) begin
         n_mismatch++;
         $display("Error %0t: outputs not clear in reset", $time);
      end
      #1 reset_n_i = 1'h1;
      for (int i = 0; i < 80; i++) go(ops[i % 4], i % 3 == 0);
      @(posedge sys_clk_i) #1 instr_valid_i = 0;
      for (int i = 0; i < 10 && q.size() > 0; i++) @(posedge sys_clk_i);
      if (q.size() > 0) n_mismatch++;
      finish_test();
   end
endmodule // imm_exec_test
`default_nettype wire
